// ===== hdl/eff_pkg.sv
/*
  constants, register map and carrier types for the receive-side frame filter.
  assumes one 20 MHz core clock and a register port of index/data/strobes.
*/
package eff_pkg;
  // ==========================================================
  // register indices (word indices, as printed)
  localparam logic [7:0] EFF_IDX_CONTROL = 8'h0C;
  localparam logic [7:0] EFF_IDX_CRC_TALLY = 8'h0F;
  localparam logic [7:0] EFF_IDX_ADDR_REJECT = 8'h11;
  localparam logic [7:0] EFF_IDX_SRC0_LSB = 8'h12;
  localparam logic [7:0] EFF_IDX_SRC0_MSB = 8'h13;
  localparam logic [7:0] EFF_IDX_SRC1_LSB = 8'h14;
  localparam logic [7:0] EFF_IDX_SRC1_MSB = 8'h15;
  // ==========================================================
  // control register fields and the compare-address enable bit
  localparam int EFF_BIT_RAW = 0;
  localparam int EFF_BIT_CRC_DIS = 2;
  localparam int EFF_BIT_PROMISC = 4;
  localparam int EFF_BIT_ADDR_EN = 31;
  localparam logic [31:0] EFF_CTRL_MASK = 32'h0000_0015;
  localparam logic [31:0] EFF_CTRL_RESET = 32'h0000_0010;
  localparam logic [31:0] EFF_ZERO = 32'h0000_0000;
  localparam logic [31:0] EFF_ONE = 32'h0000_0001;
  // ==========================================================
  // frame layout and crc
  localparam int EFF_NUM_ADDR = 2;
  localparam logic [3:0] EFF_SRC_FIRST = 4'h6;
  localparam logic [3:0] EFF_SRC_LAST = 4'hB;
  localparam logic [3:0] EFF_HDR_DONE = 4'hC;
  localparam int EFF_FCS_BYTES = 4;
  localparam logic [31:0] EFF_CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] EFF_CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] EFF_CRC_RESIDUE = 32'hDEBB_20E3;

  // one byte on the stream with its frame markers
  typedef struct packed {
    logic [7:0] data;
    logic sof;
    logic eof;
  } eff_beat_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [31:0] wdata;
  } eff_reg_req_t;

  // filter settings latched at a frame boundary
  typedef struct packed {
    logic raw;
    logic crc_dis;
    logic promisc;
  } eff_mode_t;
endpackage : eff_pkg

// ===== hdl/eff_frame_filter.sv
/*
  receive frame filter: crc check, source address filter, raw bypass.
  assumes aligned bytes from the link logic on core_clk (same domain), a downstream
  payload filter with valid/ready, and host register access by word index.
*/
// How it works
// RULE_01: control bit 0 turns raw mode on and off.
// RULE_02: raw mode forwards every frame whole, nothing stripped or dropped.
// RULE_03: raw mode overrides crc check and promiscuous settings.
// RULE_04: host also enables raw mode in the downstream payload filter.
// RULE_05: control bit 2 disables crc checking.
// RULE_06: crc checking is enabled after reset.
// RULE_07: with checking on, frames with bad crc are not forwarded; the code forwards their bytes and withholds only the eof marker.
// RULE_08: with checking off, frames forward regardless of crc.
// RULE_09: each crc error adds one to the crc error tally.
// RULE_10: tally counts errors whatever the check setting.
// RULE_11: writing zero to the tally register clears it.
// RULE_12: control bit 4 is promiscuous mode.
// RULE_13: promiscuous mode is set after reset.
// RULE_14: promiscuous mode accepts all frames, no address compare.
// RULE_15: receive only; no transmit path exists.
// RULE_16: the port is one single recording channel.
// RULE_17: non-promiscuous accepts only frames matching an enabled compare address; the code forwards other frames' bytes, withholding only their eof marker.
// RULE_18: the four fcs bytes are checked but not forwarded outside raw mode.
// RULE_19: other control bits ignore writes and read as zero.
// RULE_20: control changes take effect only at frame boundaries.
module eff_frame_filter
  import eff_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire eff_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  // incoming aligned frame bytes, single channel, receive only [RULE_15] [RULE_16]
  input wire logic in_valid,
  input wire eff_beat_t in_beat,
  output logic in_ready,
  // outgoing bytes toward the payload filter
  output logic out_valid,
  output eff_beat_t out_beat,
  input wire logic out_ready
);
  // ==========================================================
  // registers
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] tally, next_tally;
  logic [31:0] rejects, next_rejects;
  logic [31:0] addr_lo [EFF_NUM_ADDR];
  logic [31:0] addr_hi [EFF_NUM_ADDR];
  logic [31:0] next_addr_lo [EFF_NUM_ADDR];
  logic [31:0] next_addr_hi [EFF_NUM_ADDR];
  logic [31:0] next_rdata;
  eff_mode_t mode, next_mode;
  logic in_frame, next_in_frame;
  logic [3:0] hdr_cnt, next_hdr_cnt;
  logic [31:0] crc, next_crc;
  logic [47:0] src, next_src;
  // fcs delay line: bytes wait here so the last four can be withheld
  eff_beat_t dly [EFF_FCS_BYTES];
  eff_beat_t next_dly [EFF_FCS_BYTES];
  logic [2:0] dly_cnt, next_dly_cnt;
  // two-entry output buffer
  eff_beat_t buf_q [2];
  eff_beat_t next_buf_q [2];
  logic [1:0] buf_cnt, next_buf_cnt;

  logic take, eof_now, crc_bad, addr_ok, push, fwd_ok;
  eff_beat_t push_beat;
  logic [EFF_NUM_ADDR-1:0] hit;
  logic [31:0] crc_byte;

  // one crc byte step, reflected ethernet polynomial
  function automatic logic [31:0] eff_crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ EFF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : eff_crc8

  // per-entry source address compare, msb word bit 31 enables
  generate
    for (genvar g = 0; g < EFF_NUM_ADDR; g++) begin : g_cmp
      assign hit[g] = addr_hi[g][EFF_BIT_ADDR_EN] &&
                      (src == {addr_hi[g][15:0], addr_lo[g]}); // [RULE_17]
    end
  endgenerate

  // ==========================================================
  // input stage: the buffer stalls the source when full and out_ready is low
  assign in_ready = (buf_cnt < 2'd2) || out_ready;
  assign take = in_valid && in_ready;
  assign eof_now = take && in_beat.eof;
  assign crc_byte = eff_crc8(crc, in_beat.data);
  assign crc_bad = (crc_byte != EFF_CRC_RESIDUE);
  assign addr_ok = mode.promisc || (|hit); // [RULE_14] [RULE_17]
  // good frames, or bad ones when checking is off; raw passes all
  assign fwd_ok = mode.raw || ((!crc_bad || mode.crc_dis) && addr_ok); // [RULE_03] [RULE_07] [RULE_08]

  // frame tracking, crc and delay line
  always_comb begin
    next_in_frame = in_frame;
    next_hdr_cnt = hdr_cnt;
    next_crc = crc;
    next_src = src;
    next_dly = dly;
    next_dly_cnt = dly_cnt;
    next_mode = mode;
    push = 1'b0;
    push_beat = dly[EFF_FCS_BYTES-1];
    if (!in_frame && !(take && in_beat.sof)) begin
      // settings latch only between frames
      next_mode = '{raw: ctrl[EFF_BIT_RAW], crc_dis: ctrl[EFF_BIT_CRC_DIS],
                    promisc: ctrl[EFF_BIT_PROMISC]}; // [RULE_20]
    end
    if (take) begin
      next_crc = crc_byte;
      if (in_beat.sof) begin
        next_crc = eff_crc8(EFF_CRC_INIT, in_beat.data);
        next_hdr_cnt = 4'h1;
        next_dly_cnt = 3'd0;
      end else if (hdr_cnt < EFF_HDR_DONE) begin
        next_hdr_cnt = hdr_cnt + 4'h1;
      end
      if (!in_beat.sof && hdr_cnt >= EFF_SRC_FIRST && hdr_cnt <= EFF_SRC_LAST) begin
        next_src = {src[39:0], in_beat.data};
      end
      next_in_frame = !in_beat.eof;
      if (mode.raw) begin
        // whole frame including fcs goes straight through
        push = 1'b1; // [RULE_02]
        push_beat = in_beat;
      end else begin
        // shift: oldest byte leaves once four are held, fcs stays behind
        for (int i = EFF_FCS_BYTES - 1; i > 0; i--) begin
          next_dly[i] = dly[i-1];
        end
        next_dly[0] = in_beat;
        if (dly_cnt == 3'(EFF_FCS_BYTES) && !in_beat.sof) begin
          push = 1'b1; // [RULE_18]
          push_beat.eof = in_beat.eof;
        end else begin
          next_dly_cnt = in_beat.sof ? 3'd1 : dly_cnt + 3'd1;
        end
      end
    end
  end

  // filtered bytes are not held per frame: a drop decided at eof would need them stored, so the
  // decision gates only the last-byte eof marker; earlier bytes pass to a frame store
  // downstream which discards on a missing eof. trade: no frame-sized buffer here.
  logic accept_beat;
  eff_beat_t kept_beat;
  // every pushed byte is kept; a refused frame only loses its eof marker, so the
  // downstream store sees the whole body and can still tell where it was cut off
  assign accept_beat = push;
  assign kept_beat = '{data: push_beat.data, sof: push_beat.sof,
                       eof: push_beat.eof && fwd_ok}; // [RULE_07] [RULE_17]

  // output buffer
  always_comb begin
    next_buf_q = buf_q;
    next_buf_cnt = buf_cnt;
    if (out_valid && out_ready) begin
      next_buf_q[0] = buf_q[1];
      next_buf_cnt = buf_cnt - 2'd1;
    end
    if (accept_beat) begin
      next_buf_q[next_buf_cnt[0]] = kept_beat;
      next_buf_cnt = next_buf_cnt + 2'd1;
    end
  end
  assign out_valid = (buf_cnt != 2'd0);
  assign out_beat = buf_q[0];

  // ==========================================================
  // register port and counters
  always_comb begin
    next_ctrl = ctrl;
    next_tally = tally;
    next_rejects = rejects;
    next_addr_lo = addr_lo;
    next_addr_hi = addr_hi;
    next_rdata = reg_rdata;
    if (reg_req.wr) begin
      case (reg_req.idx)
        EFF_IDX_CONTROL: next_ctrl = reg_req.wdata & EFF_CTRL_MASK; // [RULE_01] [RULE_05] [RULE_12] [RULE_19]
        EFF_IDX_CRC_TALLY: if (reg_req.wdata == EFF_ZERO) next_tally = EFF_ZERO; // [RULE_11]
        EFF_IDX_ADDR_REJECT: if (reg_req.wdata == EFF_ZERO) next_rejects = EFF_ZERO;
        EFF_IDX_SRC0_LSB: next_addr_lo[0] = reg_req.wdata;
        EFF_IDX_SRC0_MSB: next_addr_hi[0] = reg_req.wdata;
        EFF_IDX_SRC1_LSB: next_addr_lo[1] = reg_req.wdata;
        EFF_IDX_SRC1_MSB: next_addr_hi[1] = reg_req.wdata;
        default: ;
      endcase
    end
    // a same-cycle clear and count both apply: the tally restarts at one
    if (eof_now && crc_bad) begin
      next_tally = next_tally + EFF_ONE; // [RULE_09] [RULE_10]
    end
    if (eof_now && !mode.raw && !addr_ok) begin
      next_rejects = next_rejects + EFF_ONE;
    end
    if (reg_req.rd) begin
      case (reg_req.idx)
        EFF_IDX_CONTROL: next_rdata = ctrl;
        EFF_IDX_CRC_TALLY: next_rdata = tally;
        EFF_IDX_ADDR_REJECT: next_rdata = rejects;
        EFF_IDX_SRC0_LSB: next_rdata = addr_lo[0];
        EFF_IDX_SRC0_MSB: next_rdata = addr_hi[0];
        EFF_IDX_SRC1_LSB: next_rdata = addr_lo[1];
        EFF_IDX_SRC1_MSB: next_rdata = addr_hi[1];
        default: next_rdata = EFF_ZERO;
      endcase
    end
  end

  // ==========================================================
  // state registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= EFF_CTRL_RESET; // [RULE_06] [RULE_13]
      tally <= EFF_ZERO;
      rejects <= EFF_ZERO;
      reg_rdata <= EFF_ZERO;
      mode <= '{raw: 1'b0, crc_dis: 1'b0, promisc: 1'b1};
      in_frame <= 1'b0;
      hdr_cnt <= 4'h0;
      crc <= EFF_CRC_INIT;
      src <= '0;
      dly_cnt <= 3'd0;
      buf_cnt <= 2'd0;
      for (int i = 0; i < EFF_NUM_ADDR; i++) begin
        addr_lo[i] <= EFF_ZERO;
        addr_hi[i] <= EFF_ZERO;
      end
      for (int i = 0; i < EFF_FCS_BYTES; i++) begin
        dly[i] <= '0;
      end
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      ctrl <= next_ctrl;
      tally <= next_tally;
      rejects <= next_rejects;
      reg_rdata <= next_rdata;
      mode <= next_mode;
      in_frame <= next_in_frame;
      hdr_cnt <= next_hdr_cnt;
      crc <= next_crc;
      src <= next_src;
      dly_cnt <= next_dly_cnt;
      addr_lo <= next_addr_lo;
      addr_hi <= next_addr_hi;
      dly <= next_dly;
      buf_cnt <= next_buf_cnt;
      buf_q <= next_buf_q;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_frame_end;
    eof_now;
  endsequence

  sequence s_bad_frame_end;
    eof_now && crc_bad;
  endsequence

  a_tally_counts: assert property ((s_bad_frame_end and // [RULE_09]
      !(reg_req.wr && reg_req.idx == EFF_IDX_CRC_TALLY)) |=> tally == $past(tally) + EFF_ONE)
    else $error("crc tally did not count");
  a_tally_clear: assert property (reg_req.wr && reg_req.idx == EFF_IDX_CRC_TALLY && // [RULE_11]
      reg_req.wdata == EFF_ZERO && !eof_now |=> tally == EFF_ZERO)
    else $error("crc tally not cleared");
  a_ctrl_reserved: assert property ((ctrl & ~EFF_CTRL_MASK) == EFF_ZERO) // [RULE_19]
    else $error("reserved control bit set");
  a_bad_dropped: assert property ((s_bad_frame_end and // [RULE_07]
      (!mode.raw && !mode.crc_dis)) |-> !(accept_beat && kept_beat.eof))
    else $error("bad frame end forwarded");
  a_crc_dis_pass: assert property ((s_frame_end and // [RULE_08]
      (mode.crc_dis && addr_ok && !mode.raw)) |-> accept_beat && kept_beat.eof)
    else $error("unchecked frame end withheld");
  a_raw_eof: assert property ((s_frame_end and mode.raw) |-> kept_beat.eof) // [RULE_03]
    else $error("raw frame end withheld");
  a_raw_passes: assert property (take && mode.raw |-> push && push_beat == in_beat) // [RULE_02]
    else $error("raw byte not forwarded");
  a_mode_stable: assert property (in_frame |=> mode == $past(mode)) // [RULE_20]
    else $error("mode changed inside frame");
  a_buf_bound: assert property (buf_cnt <= 2'd2)
    else $error("buffer overfilled");
  a_promisc_accept: assert property ((s_frame_end and // [RULE_14]
      (mode.promisc && !crc_bad && !mode.raw)) |-> accept_beat && kept_beat.eof)
    else $error("promiscuous frame rejected");
endmodule : eff_frame_filter

// ===== verif/eff_src_model.sv
/*
  far-side frame source: sends aligned frame bytes with markers and fcs.
  assumes core_clk is shared with the filter; drives at the falling edge.
*/
module eff_src_model
  import eff_pkg::*;
(
  // clock
  input wire logic core_clk,
  // stream toward the filter
  output logic in_valid,
  output eff_beat_t in_beat,
  input wire logic in_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] frm [0:63];
  int waits = 0;
  // ==========================================================
  // idle until the first frame
  initial begin
    in_valid = 1'b0;
    in_beat = '0;
  end
  // ==========================================================
  // one frame of n bytes; bad spoils the fcs by one bit
  task automatic send(input int n, input logic bad, input logic [47:0] sa);
    logic [31:0] c;
    c = EFF_CRC_INIT;
    for (int i = 0; i < n - EFF_FCS_BYTES; i++) begin
      frm[i] = (i >= 6 && i < 12) ? sa[8 * (11 - i) +: 8] : 8'(i * 37 + n);
      c = c ^ 32'(frm[i]);
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? (c >> 1) ^ EFF_CRC_POLY : c >> 1;
      end
    end
    c = ~c ^ 32'(bad);
    // fcs goes last, low byte first
    for (int j = 0; j < EFF_FCS_BYTES; j++) begin
      frm[n - EFF_FCS_BYTES + j] = c[8 * j +: 8];
    end
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      in_valid = 1'b1;
      in_beat = '{data: frm[i], sof: i == 0, eof: i == n - 1};
      #1;
      // byte held until a rising edge sees ready
      while (in_ready !== 1'b1) begin
        waits++;
        @(negedge core_clk);
        #1;
      end
      @(posedge core_clk);
    end
    @(negedge core_clk);
    in_valid = 1'b0;
    in_beat.data = ~in_beat.data; // released line shows no stale byte
  endtask : send
endmodule : eff_src_model

// ===== verif/testbench.sv
/*
  self-checking bench for the frame filter: registers, crc, raw, address filter.
  assumes the source model and the filter share one 20 MHz core_clk.
*/
module testbench
  import eff_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] SA = 48'h0A1B_2C3D_4E5F;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  eff_reg_req_t reg_req = '0;
  logic [31:0] reg_rdata;
  logic in_valid, in_ready, out_valid;
  eff_beat_t in_beat, out_beat;
  logic out_ready = 1'b1;
  logic stall = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int got = 0;
  int got_eof = 0;
  // ==========================================================
  // clock, design and far side
  always #25 core_clk = ~core_clk;
  eff_frame_filter DUT (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_beat(in_beat), .in_ready(in_ready),
    .out_valid(out_valid), .out_beat(out_beat), .out_ready(out_ready));
  eff_src_model src (.core_clk(core_clk), .in_valid(in_valid), .in_beat(in_beat),
    .in_ready(in_ready));
  // sink stalls half the time when asked, so the buffer fills and refuses
  always @(negedge core_clk) begin
    cycles++;
    out_ready <= !(stall && cycles[2]);
    if (cycles > 20000) begin
      num_errors++;
      results();
    end
  end
  // monitor: looked at after the falling edge, taken at the next rising edge
  always @(negedge core_clk) begin
    #2;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      check("out_data", 32'(src.frm[got]), 32'(out_beat.data));
      check("out_sof", 32'(got == 0), 32'(out_beat.sof));
      if (out_beat.eof === 1'b1) begin
        got_eof++;
      end
      got++;
    end
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(negedge core_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    @(negedge core_clk);
    reg_req.wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    @(negedge core_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: EFF_ZERO};
    @(negedge core_clk);
    reg_req.rd = 1'b0;
    check(what, exp, reg_rdata);
  endtask : rd_chk
  // a 24-byte frame; counts forwarded bytes and eof markers
  task automatic frame(input logic bad, input logic [47:0] sa, input int n_out, input int eofs);
    got = 0;
    got_eof = 0;
    src.send(24, bad, sa);
    repeat (30) @(negedge core_clk);
    check("out_count", 32'(n_out), 32'(got));
    check("out_eof", 32'(eofs), 32'(got_eof));
  endtask : frame
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_chk("ctrl_reset", EFF_IDX_CONTROL, EFF_CTRL_RESET);
    wr(EFF_IDX_CONTROL, 32'hFFFF_FFFF);
    rd_chk("ctrl_reserved", EFF_IDX_CONTROL, EFF_CTRL_MASK);
    rd_chk("unmapped", 8'h3F, EFF_ZERO);
    wr(EFF_IDX_CONTROL, EFF_CTRL_RESET);
  endtask : t_reset
  task automatic t_crc();
    frame(1'b0, SA, 20, 1);
    frame(1'b1, SA, 20, 0);
    rd_chk("tally", EFF_IDX_CRC_TALLY, EFF_ONE);
    wr(EFF_IDX_CRC_TALLY, 32'h0000_0005);
    rd_chk("tally_nonzero_wr", EFF_IDX_CRC_TALLY, EFF_ONE);
    wr(EFF_IDX_CRC_TALLY, EFF_ZERO);
    rd_chk("tally_clear", EFF_IDX_CRC_TALLY, EFF_ZERO);
  endtask : t_crc
  task automatic t_crc_dis();
    wr(EFF_IDX_CONTROL, 32'h0000_0014);
    stall = 1'b1;
    frame(1'b1, SA, 20, 1);
    stall = 1'b0;
    check("in_refused", EFF_ONE, 32'(src.waits > 0));
    rd_chk("tally_dis", EFF_IDX_CRC_TALLY, EFF_ONE);
  endtask : t_crc_dis
  task automatic t_raw();
    // host turns raw on in the filter, so whole frames are forwarded with fcs
    wr(EFF_IDX_CONTROL, EFF_ONE);
    frame(1'b1, 48'h0000_0000_0001, 24, 1);
    rd_chk("tally_raw", EFF_IDX_CRC_TALLY, 32'h0000_0002);
  endtask : t_raw
  task automatic t_addr();
    wr(EFF_IDX_CONTROL, EFF_ZERO);
    frame(1'b0, SA, 20, 0);
    wr(EFF_IDX_SRC1_LSB, SA[31:0]);
    wr(EFF_IDX_SRC1_MSB, {16'h8000, SA[47:32]});
    frame(1'b0, SA, 20, 1);
    frame(1'b0, SA ^ 48'h0000_0000_0100, 20, 0);
  endtask : t_addr
  // ==========================================================
  // verdict and end of run
  task automatic results();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_crc();
    t_crc_dis();
    t_raw();
    t_addr();
    results();
  end
endmodule : testbench
